// >>> hw/mbm_matrix.sv
/*
  Nine-master, seven-slave bus matrix top.
  Assumes AHB-lite masters and single-slave AHB buses on core_clk,
  and a boot pin that is asynchronous to core_clk.
*/
`timescale 1ns/1ps
`default_nettype none
module mbm_matrix (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic boot_source_select_pin,
  input wire logic remap_cmd,
  input wire logic [6:0] arb_fixed,
  input wire logic [13:0] arb_dflt_type,
  input wire logic [27:0] arb_dflt_master,
  input wire logic [55:0] arb_slot_limit,
  input wire logic [287:0] m_haddr,
  input wire logic [17:0] m_htrans,
  input wire logic [8:0] m_hwrite,
  input wire logic [26:0] m_hsize,
  input wire logic [26:0] m_hburst,
  input wire logic [287:0] m_hwdata,
  output logic [8:0] m_hready,
  output logic [8:0] m_hresp,
  output logic [287:0] m_hrdata,
  output logic [6:0] s_hsel,
  output logic [223:0] s_haddr,
  output logic [13:0] s_htrans,
  output logic [6:0] s_hwrite,
  output logic [20:0] s_hsize,
  output logic [20:0] s_hburst,
  output logic [223:0] s_hwdata,
  output logic [6:0] s_hready,
  input wire logic [6:0] s_hreadyout,
  input wire logic [6:0] s_hresp,
  input wire logic [223:0] s_hrdata
);
  localparam int NM = mbm_pkg::NUM_M;
  localparam int NS = mbm_pkg::NUM_S;

  mbm_pkg::mbm_mst_state_type st_ff [NM];
  logic [31:0] p_addr_ff [NM];
  logic [1:0] p_trans_ff [NM];
  logic [NM-1:0] p_write_ff;
  logic [2:0] p_size_ff [NM];
  logic [2:0] p_burst_ff [NM];
  logic [2:0] tgt_ff [NM];
  logic [31:0] rdata_ff [NM];
  logic [NM-1:0] resp_ff;
  logic [NM-1:0] burst_ff;
  logic [3:0] dm_ff [NS];
  logic [NM-1:0] accept;
  logic [NM-1:0] issue;
  logic [NM-1:0] done;
  logic [NM-1:0] req [NS];
  logic [NS-1:0] hold;
  logic sync1_ff;
  logic [1:0] settle_ff;
  logic sync2_ff;
  logic boot_ext_ff;
  logic sampled_ff;
  logic remapped_ff;
  wire logic [NM-1:0] dec_hit;
  wire logic [2:0] dec_idx [NM];
  wire logic [NS-1:0] gnt_vld;
  wire logic [3:0] gnt_idx [NS];
  wire logic [3:0] own_idx [NS];
  wire logic [NS-1:0] own_vld;

  // One private decoder per master, numbered as the master ports.
  for (genvar m = 0; m < NM; m++) begin : g_dec // R2 R3
    mbm_decoder #(
      .MASTER_ID(m)
    ) u_dec (
      .addr(m_haddr[32*m +: 32]),
      .boot_ext(boot_ext_ff),
      .remapped(remapped_ff),
      .hit(dec_hit[m]),
      .slave_idx(dec_idx[m])
    );
  end

  // One independently configured arbiter per slave port.
  for (genvar s = 0; s < NS; s++) begin : g_arb // R4 R5
    mbm_arbiter #(
      .N(NM),
      .SLOTW(mbm_pkg::SLOTW)
    ) u_arb (
      .core_clk(core_clk),
      .rst(rst),
      .req(req[s]),
      .hold(hold[s]),
      .advance(s_hreadyout[s]),
      .scheme_fixed(arb_fixed[s]),
      .dflt_type(arb_dflt_type[2*s +: 2]),
      .dflt_master(arb_dflt_master[4*s +: 4]),
      .slot_limit(arb_slot_limit[8*s +: 8]),
      .grant_valid(gnt_vld[s]),
      .grant_idx(gnt_idx[s]),
      .owner_idx(own_idx[s]),
      .owner_valid(own_vld[s])
    );
  end

  // Per-master handshake terms; issue also depends on the slave's arbitration among all masters.
  always_comb begin
    for (int i = 0; i < NM; i++) begin
      accept[i] = (st_ff[i] == mbm_pkg::MST_IDLE) && m_htrans[2*i+1];
      issue[i] = (st_ff[i] == mbm_pkg::MST_REQ) && gnt_vld[tgt_ff[i]] // R1
        && (gnt_idx[tgt_ff[i]] == 4'(i)) && s_hreadyout[tgt_ff[i]];
      done[i] = (st_ff[i] == mbm_pkg::MST_DATA) && s_hreadyout[tgt_ff[i]];
    end
  end

  // Requests per slave, and the burst hold of each slave's owner.
  always_comb begin
    for (int s = 0; s < NS; s++) begin
      for (int i = 0; i < NM; i++) begin
        req[s][i] = (st_ff[i] == mbm_pkg::MST_REQ) && (tgt_ff[i] == 3'(s));
      end
      hold[s] = own_vld[s] && burst_ff[own_idx[s]] // R7
        && ((st_ff[own_idx[s]] != mbm_pkg::MST_REQ) || (tgt_ff[own_idx[s]] == 3'(s)));
    end
  end

  // Master sequence: take the address, wait for grant, run the data phase.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < NM; i++) begin
        st_ff[i] <= mbm_pkg::MST_IDLE;
      end
    end else begin
      for (int i = 0; i < NM; i++) begin
        case (st_ff[i])
          mbm_pkg::MST_IDLE: begin
            if (accept[i]) begin
              st_ff[i] <= dec_hit[i] ? mbm_pkg::MST_REQ : mbm_pkg::MST_ERR; // R15
            end
          end
          mbm_pkg::MST_REQ: begin
            if (issue[i]) begin // R16
              st_ff[i] <= mbm_pkg::MST_DATA;
            end
          end
          mbm_pkg::MST_DATA: begin
            if (done[i]) begin
              st_ff[i] <= s_hresp[tgt_ff[i]] ? mbm_pkg::MST_ERR : mbm_pkg::MST_IDLE;
            end
          end
          mbm_pkg::MST_ERR: begin
            st_ff[i] <= mbm_pkg::MST_IDLE;
          end
          default: begin
            st_ff[i] <= mbm_pkg::MST_IDLE;
          end
        endcase
      end
    end
  end

  // Address and control are held here once taken from the master.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      p_write_ff <= '0;
      for (int i = 0; i < NM; i++) begin
        p_addr_ff[i] <= 32'h0000_0000;
        p_trans_ff[i] <= mbm_pkg::HTRANS_IDLE;
        p_size_ff[i] <= 3'h0;
        p_burst_ff[i] <= mbm_pkg::HBURST_SINGLE;
        tgt_ff[i] <= mbm_pkg::SL_ROM;
      end
    end else begin
      for (int i = 0; i < NM; i++) begin
        if (accept[i]) begin // R16
          p_addr_ff[i] <= m_haddr[32*i +: 32];
          p_trans_ff[i] <= m_htrans[2*i +: 2];
          p_write_ff[i] <= m_hwrite[i];
          p_size_ff[i] <= m_hsize[3*i +: 3];
          p_burst_ff[i] <= m_hburst[3*i +: 3];
          tgt_ff[i] <= dec_idx[i];
        end
      end
    end
  end

  // Read data and response flags returned to each master.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      resp_ff <= '0;
      for (int i = 0; i < NM; i++) begin
        rdata_ff[i] <= mbm_pkg::RDATA_RST;
      end
    end else begin
      for (int i = 0; i < NM; i++) begin
        if (accept[i]) begin
          resp_ff[i] <= 1'b0;
        end else if (done[i]) begin
          rdata_ff[i] <= s_hrdata[32*tgt_ff[i] +: 32];
        end else if (st_ff[i] == mbm_pkg::MST_ERR) begin
          resp_ff[i] <= 1'b1; // R15
        end
      end
    end
  end

  // Burst tracking; an idle transfer ends an undefined-length burst.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      burst_ff <= '0;
    end else begin
      for (int i = 0; i < NM; i++) begin
        if (accept[i]) begin
          burst_ff[i] <= dec_hit[i] && (m_hburst[3*i +: 3] != mbm_pkg::HBURST_SINGLE);
        end else if (st_ff[i] == mbm_pkg::MST_IDLE && m_htrans[2*i +: 2] == mbm_pkg::HTRANS_IDLE) begin
          burst_ff[i] <= 1'b0; // R7
        end
      end
    end
  end

  // Data-phase owner of each slave, for write data steering.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      for (int s = 0; s < NS; s++) begin
        dm_ff[s] <= 4'h0;
      end
    end else begin
      for (int s = 0; s < NS; s++) begin
        if (gnt_vld[s] && s_hreadyout[s]) begin
          dm_ff[s] <= gnt_idx[s];
        end
      end
    end
  end

  // Slave buses carry the granted master; a broken burst restarts as INCR.
  always_comb begin
    for (int s = 0; s < NS; s++) begin
      s_hsel[s] = gnt_vld[s];
      s_haddr[32*s +: 32] = p_addr_ff[gnt_idx[s]];
      s_hwrite[s] = p_write_ff[gnt_idx[s]];
      s_hsize[3*s +: 3] = p_size_ff[gnt_idx[s]];
      s_hburst[3*s +: 3] = p_burst_ff[gnt_idx[s]];
      s_htrans[2*s +: 2] = p_trans_ff[gnt_idx[s]];
      if (!gnt_vld[s]) begin
        s_htrans[2*s +: 2] = mbm_pkg::HTRANS_IDLE;
      end else if (p_trans_ff[gnt_idx[s]] == mbm_pkg::HTRANS_SEQ && !hold[s]) begin
        s_htrans[2*s +: 2] = mbm_pkg::HTRANS_NONSEQ; // R7
        s_hburst[3*s +: 3] = mbm_pkg::HBURST_INCR;
      end
      s_hwdata[32*s +: 32] = m_hwdata[32*dm_ff[s] +: 32];
      s_hready[s] = s_hreadyout[s]; // R16
    end
  end

  // Master answers: ready when idle, two-cycle error on abort.
  always_comb begin
    for (int i = 0; i < NM; i++) begin
      m_hready[i] = (st_ff[i] == mbm_pkg::MST_IDLE);
      m_hresp[i] = (st_ff[i] == mbm_pkg::MST_ERR) || ((st_ff[i] == mbm_pkg::MST_IDLE) && resp_ff[i]);
      m_hrdata[32*i +: 32] = rdata_ff[i];
    end
  end

  // Boot pin synchroniser; the second stage alone feeds the sample.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      sync1_ff <= 1'b0;
      sync2_ff <= 1'b0;
    end else begin
      sync1_ff <= boot_source_select_pin;
      sync2_ff <= sync1_ff;
    end
  end

  // Boot choice is caught once the synchroniser has settled after reset.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      settle_ff <= 2'h0;
      sampled_ff <= 1'b0;
      boot_ext_ff <= 1'b0;
    end else if (!sampled_ff) begin
      if (settle_ff == mbm_pkg::BOOT_SETTLE) begin
        boot_ext_ff <= !sync2_ff; // R9
        sampled_ff <= 1'b1;
      end else begin
        settle_ff <= settle_ff + 2'h1;
      end
    end
  end

  // Remap is sticky until the next reset.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      remapped_ff <= 1'b0;
    end else if (remap_cmd) begin
      remapped_ff <= 1'b1; // R10
    end
  end

  AST_BOOT_HOLD: assert property (@(posedge core_clk) disable iff (rst) // R9
    (sampled_ff && $past(sampled_ff)) |-> $stable(boot_ext_ff))
    else $error("Boot choice changed after it was sampled.");

  AST_UI_ONLY_CPU: assert property (@(posedge core_clk) disable iff (rst) // R11
    s_hsel[3] |-> (gnt_idx[3] >= 4'h7))
    else $error("Shared register layer granted to a non-processor master.");

  AST_BRIDGE_PATH: assert property (@(posedge core_clk) disable iff (rst) // R12
    s_hsel[6] |-> (gnt_idx[6] == 4'h3 || gnt_idx[6] >= 4'h6))
    else $error("Peripheral bridge granted to a forbidden master.");

  for (genvar m = 0; m < NM; m++) begin : g_chk
    AST_ABORT_SEQ: assert property (@(posedge core_clk) disable iff (rst) // R15
      (accept[m] && !dec_hit[m]) |=> (!m_hready[m] && m_hresp[m]) ##1 (m_hready[m] && m_hresp[m]))
      else $error("Unmapped access did not end in a two-cycle abort.");

    AST_WAIT_HOLD: assert property (@(posedge core_clk) disable iff (rst) // R16
      (accept[m] && dec_hit[m]) |=> (!m_hready[m] && !m_hresp[m]) ##1 !m_hready[m])
      else $error("Master released before its transfer reached a slave.");

    AST_ISSUE_FREE: assert property (@(posedge core_clk) disable iff (rst) // R1
      (st_ff[m] == mbm_pkg::MST_REQ && req[tgt_ff[m]] == (9'h001 << m)
        && s_hreadyout[tgt_ff[m]] && !hold[tgt_ff[m]]) |=> (st_ff[m] == mbm_pkg::MST_DATA))
      else $error("Lone request to a free slave was not issued.");

    if (m >= mbm_pkg::MS_CPU_DATA) begin : g_cpu
      AST_REMAP_ZERO: assert property (@(posedge core_clk) disable iff (rst) // R10
        (remapped_ff && m_haddr[32*m+20 +: 12] == 12'h000)
          |-> (dec_hit[m] && dec_idx[m] == mbm_pkg::SL_SRAM80))
        else $error("Remapped address zero did not reach internal SRAM.");

      AST_BANK_PERIPH: assert property (@(posedge core_clk) disable iff (rst) // R14
        (m_haddr[32*m+28 +: 4] == mbm_pkg::BANK_PERIPH)
          |-> (dec_hit[m] && dec_idx[m] == mbm_pkg::SL_BRIDGE))
        else $error("Top bank did not decode to the peripheral bridge.");
    end
  end
endmodule // mbm_matrix
`default_nettype wire

// >>> hw/mbm_pkg.sv
/*
  Shared constants and types of the multilayer bus matrix.
  Assumes AHB-lite masters and slaves on core_clk.
*/
// Operation
// [R1] Nine masters run concurrently on distinct slaves.
// [R2] Each master owns a private address decoder.
// [R3] Masters numbered 0 to 8 in fixed order.
// [R4] Slaves numbered 0 to 6 in fixed order.
// [R5] Every slave has its own programmable arbiter.
// [R6] Fixed priority or round robin with defaults.
// [R7] Bursts break at slot limit; undefined lengths.
// [R8] Boot area targets internal, external or remapped.
// [R9] Boot pin sampled at reset picks memory.
// [R10] Remap puts internal SRAM at address zero.
// [R11] Shared register layer reachable by processor only.
// [R12] Forbidden paths abort; bridge limited masters.
// [R13] Memories and external buses open to all.
// [R14] Sixteen banks of 256 Mbytes decoded.
// [R15] Unused areas answer with an abort.
// [R16] AHB protocol; masters hold, slaves stretch.
package mbm_pkg;
  localparam int NUM_M = 9;
  localparam int NUM_S = 7;
  localparam int AW = 32;
  localparam int DW = 32;
  localparam int MIW = 4;
  localparam int SLOTW = 8;
  localparam int MS_USB_HOST = 0;
  localparam int MS_IMAGE = 1;
  localparam int MS_GRAPHICS = 2;
  localparam int MS_DMA = 3;
  localparam int MS_ETH = 4;
  localparam int MS_DISPLAY = 5;
  localparam int MS_PERIPH_DMA = 6;
  localparam int MS_CPU_DATA = 7;
  localparam int MS_CPU_INSTR = 8;
  localparam logic [2:0] SL_ROM = 3'h0;
  localparam logic [2:0] SL_SRAM80 = 3'h1;
  localparam logic [2:0] SL_SRAM16 = 3'h2;
  localparam logic [2:0] SL_UI = 3'h3;
  localparam logic [2:0] SL_EXT0 = 3'h4;
  localparam logic [2:0] SL_EXT1 = 3'h5;
  localparam logic [2:0] SL_BRIDGE = 3'h6;
  localparam logic [1:0] HTRANS_IDLE = 2'h0;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] HTRANS_SEQ = 2'h3;
  localparam logic [2:0] HBURST_SINGLE = 3'h0;
  localparam logic [2:0] HBURST_INCR = 3'h1;
  localparam logic [1:0] DEF_NONE = 2'h0;
  localparam logic [1:0] DEF_LAST = 2'h1;
  localparam logic [1:0] DEF_FIXED = 2'h2;
  localparam logic [3:0] BANK_INT = 4'h0;
  localparam logic [3:0] BANK_EXT0_LO = 4'h1;
  localparam logic [3:0] BANK_EXT0_HI = 4'h6;
  localparam logic [3:0] BANK_EXT1_LO = 4'h7;
  localparam logic [3:0] BANK_EXT1_HI = 4'h9;
  localparam logic [3:0] BANK_PERIPH = 4'hF;
  localparam logic [7:0] AREA_BOOT = 8'h00;
  localparam logic [7:0] AREA_SRAM_A = 8'h01;
  localparam logic [7:0] AREA_SRAM_C = 8'h03;
  localparam logic [7:0] AREA_ROM = 8'h04;
  localparam logic [7:0] AREA_SRAM16 = 8'h05;
  localparam logic [7:0] AREA_UI = 8'h06;
  localparam logic [8:0] ACC_ALL = 9'h1FF;
  localparam logic [8:0] ACC_UI = 9'h180;
  localparam logic [8:0] ACC_BRIDGE = 9'h1C8;
  localparam logic [NUM_S-1:0][NUM_M-1:0] ACCESS =
    {ACC_BRIDGE, ACC_ALL, ACC_ALL, ACC_UI, ACC_ALL, ACC_ALL, ACC_ALL};
  localparam logic [1:0] BOOT_SETTLE = 2'h2;
  localparam logic [31:0] RDATA_RST = 32'h0000_0000;
  typedef enum logic [1:0] {MST_IDLE, MST_REQ, MST_DATA, MST_ERR} mbm_mst_state_type;
endpackage

// >>> hw/mbm_decoder.sv
/*
  Private address decoder of one master.
  Assumes boot and remap state are stable core_clk registers.
*/
`timescale 1ns/1ps
`default_nettype none
module mbm_decoder #(
  parameter int MASTER_ID = 0
) (
  input wire logic [31:0] addr,
  input wire logic boot_ext,
  input wire logic remapped,
  output logic hit,
  output logic [2:0] slave_idx
);
  localparam bit IS_CPU = (MASTER_ID >= mbm_pkg::MS_CPU_DATA);
  logic raw_hit;
  logic [3:0] bank;
  logic [7:0] area;
  assign bank = addr[31:28];
  assign area = addr[27:20];
  // Bank decode, then the internal area decode inside bank zero.
  always_comb begin
    raw_hit = 1'b1;
    slave_idx = mbm_pkg::SL_ROM;
    if (bank == mbm_pkg::BANK_INT) begin // R14
      if (area == mbm_pkg::AREA_BOOT) begin
        if (IS_CPU && remapped) begin // R10
          slave_idx = mbm_pkg::SL_SRAM80;
        end else if (IS_CPU && boot_ext) begin // R8
          slave_idx = mbm_pkg::SL_EXT0;
        end else begin
          slave_idx = mbm_pkg::SL_ROM;
        end
      end else if (area >= mbm_pkg::AREA_SRAM_A && area <= mbm_pkg::AREA_SRAM_C) begin
        slave_idx = mbm_pkg::SL_SRAM80;
      end else if (area == mbm_pkg::AREA_ROM) begin
        slave_idx = mbm_pkg::SL_ROM;
      end else if (area == mbm_pkg::AREA_SRAM16) begin
        slave_idx = mbm_pkg::SL_SRAM16;
      end else if (area == mbm_pkg::AREA_UI) begin
        slave_idx = mbm_pkg::SL_UI;
      end else begin
        raw_hit = 1'b0; // R15
      end
    end else if (bank >= mbm_pkg::BANK_EXT0_LO && bank <= mbm_pkg::BANK_EXT0_HI) begin
      slave_idx = mbm_pkg::SL_EXT0;
    end else if (bank >= mbm_pkg::BANK_EXT1_LO && bank <= mbm_pkg::BANK_EXT1_HI) begin
      slave_idx = mbm_pkg::SL_EXT1;
    end else if (bank == mbm_pkg::BANK_PERIPH) begin
      slave_idx = mbm_pkg::SL_BRIDGE;
    end else begin
      raw_hit = 1'b0; // R15
    end
    // The access matrix turns a forbidden path into a miss.
    hit = raw_hit && mbm_pkg::ACCESS[slave_idx][MASTER_ID]; // R12 R13
  end
endmodule // mbm_decoder
`default_nettype wire

// >>> hw/mbm_arbiter.sv
/*
  Per-slave arbiter with fixed or round-robin scheme and burst slots.
  Assumes advance is high while the slave bus can take an address.
*/
`timescale 1ns/1ps
`default_nettype none
module mbm_arbiter #(
  parameter int N = 9,
  parameter int SLOTW = 8
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [N-1:0] req,
  input wire logic hold,
  input wire logic advance,
  input wire logic scheme_fixed,
  input wire logic [1:0] dflt_type,
  input wire logic [3:0] dflt_master,
  input wire logic [SLOTW-1:0] slot_limit,
  output logic grant_valid,
  output logic [3:0] grant_idx,
  output logic [3:0] owner_idx,
  output logic owner_valid
);
  localparam logic [SLOTW-1:0] ONE = SLOTW'(1);
  logic [3:0] owner_ff;
  logic owner_vld_ff;
  logic parked_ff;
  logic [SLOTW-1:0] beats_ff;
  logic keep;

  // Highest set index wins.
  function automatic logic [3:0] pick_fixed(input logic [N-1:0] r);
    logic [3:0] w;
    w = 4'h0;
    for (int i = 0; i < N; i++) begin
      if (r[i]) begin
        w = 4'(i);
      end
    end
    return w;
  endfunction

  // First set index after the previous owner, cyclic.
  function automatic logic [3:0] pick_rr(input logic [N-1:0] r, input logic [3:0] last);
    logic [3:0] w;
    int k;
    w = last;
    for (int j = N; j >= 1; j--) begin
      k = (int'(last) + j) % N;
      if (r[k]) begin
        w = 4'(k);
      end
    end
    return w;
  endfunction

  // A burst keeps its owner until the slot limit; zero means no limit.
  assign keep = hold && owner_vld_ff && (slot_limit == '0 || beats_ff < slot_limit); // R7
  assign owner_idx = owner_ff;
  assign owner_valid = owner_vld_ff;

  // Grant choice for the current address cycle.
  always_comb begin
    grant_valid = 1'b0;
    grant_idx = owner_ff;
    if (keep) begin
      grant_valid = req[owner_ff];
    end else if (|req) begin
      grant_valid = 1'b1;
      if (scheme_fixed) begin // R6
        grant_idx = pick_fixed(req);
      end else if (parked_ff && owner_vld_ff && req[owner_ff]) begin
        grant_idx = owner_ff;
      end else begin
        grant_idx = pick_rr(req, owner_ff);
      end
    end
  end

  // Owner and parking on the default master when the slave goes idle.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      owner_ff <= 4'h0;
      owner_vld_ff <= 1'b0;
      parked_ff <= 1'b0;
    end else if (advance && grant_valid) begin
      owner_ff <= grant_idx;
      owner_vld_ff <= 1'b1;
      parked_ff <= 1'b0;
    end else if (advance && !(|req) && !keep) begin
      case (dflt_type) // R6
        mbm_pkg::DEF_NONE: begin
          owner_vld_ff <= 1'b0;
          parked_ff <= 1'b0;
        end
        mbm_pkg::DEF_LAST: begin
          parked_ff <= owner_vld_ff;
        end
        mbm_pkg::DEF_FIXED: begin
          owner_ff <= dflt_master;
          owner_vld_ff <= 1'b1;
          parked_ff <= 1'b1;
        end
        default: begin
          parked_ff <= 1'b0;
        end
      endcase
    end
  end

  // Beats issued by the owner in one unbroken run.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      beats_ff <= '0;
    end else if (advance && grant_valid) begin
      beats_ff <= keep ? beats_ff + ONE : ONE; // R7
    end
  end

  AST_SLOT_LIMIT: assert property (@(posedge core_clk) disable iff (rst) // R7
    (slot_limit != '0 && $stable(slot_limit)) |-> (beats_ff <= slot_limit))
    else $error("Burst run exceeded the slot limit.");

  AST_FIXED_PRIO: assert property (@(posedge core_clk) disable iff (rst) // R6
    (scheme_fixed && !keep && (|req)) |-> (grant_valid && ((req >> grant_idx) == N'(1))))
    else $error("Fixed priority did not grant the highest requester.");
endmodule // mbm_arbiter
`default_nettype wire

// >>> tb/mbm_slave_model.sv
/*
  Stand-ins for the seven AHB slaves behind the bus matrix.
  Assumes single-slave AHB buses on core_clk and the reset of the matrix.
*/
`timescale 1ns/1ps
`default_nettype none
module mbm_slave_model (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic slow,
  input wire logic [6:0] s_hsel,
  input wire logic [13:0] s_htrans,
  input wire logic [6:0] s_hready,
  output logic [6:0] s_hreadyout,
  output logic [6:0] s_hresp,
  output logic [223:0] s_hrdata
);
  // Each slave returns a word naming itself and the inverse outside its data phase.
  for (genvar s = 0; s < 7; s++) begin : g_slv
    logic dph_ff;
    logic wait_ff;
    always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
        dph_ff <= 1'b0;
        wait_ff <= 1'b0;
      end else begin
        if (s_hready[s]) begin
          dph_ff <= s_hsel[s] & s_htrans[2*s+1];
        end
        wait_ff <= dph_ff & slow & ~wait_ff;
      end
    end
    // A slow slave stretches every data phase by one wait state.
    assign s_hreadyout[s] = ~(dph_ff & slow & ~wait_ff);
    assign s_hresp[s] = 1'b0;
    assign s_hrdata[32*s+:32] = dph_ff ? (32'hC0DE_0000 | 32'(s)) : ~(32'hC0DE_0000 | 32'(s));
  end
endmodule // mbm_slave_model
`default_nettype wire

// >>> tb/test_multilayer_bus_matrix.sv
/*
  Self-checking bench of the bus matrix: decoding, boot, remap and arbitration.
  Assumes the slave model answers with a word that names the slave.
*/
`timescale 1ns/1ps
`default_nettype none
module test_multilayer_bus_matrix;
  logic core_clk, rst, boot_source_select_pin, remap_cmd, slow;
  logic [6:0] arb_fixed, s_hsel, s_hwrite, s_hready, s_hreadyout, s_hresp;
  logic [13:0] s_htrans, dflt_type;
  logic [27:0] dflt_master;
  logic [20:0] s_hsize, s_hburst;
  logic [223:0] s_haddr, s_hwdata, s_hrdata;
  logic [287:0] m_haddr, m_hwdata, m_hrdata;
  logic [17:0] m_htrans;
  logic [8:0] m_hwrite, m_hready, m_hresp;
  logic [26:0] m_hsize, m_hburst;
  int n_fail = 0;
  int n_tests = 0;
  localparam logic [31:0] ADR [9] = '{32'h0040_0000, 32'h0010_0000, 32'h0050_0000,
    32'h0060_0000, 32'h1000_0000, 32'h7000_0000, 32'hF000_0000, 32'hA000_0000, 32'h0070_0000};
  localparam int EXP [9] = '{0, 1, 2, 3, 4, 5, 6, -1, -1};

  mbm_matrix dut (.core_clk(core_clk), .rst(rst), .boot_source_select_pin(boot_source_select_pin),
    .remap_cmd(remap_cmd), .arb_fixed(arb_fixed), .arb_dflt_type(dflt_type),
    .arb_dflt_master(dflt_master), .arb_slot_limit(56'h00_0000_0000_0000),
    .m_haddr(m_haddr), .m_htrans(m_htrans), .m_hwrite(m_hwrite), .m_hsize(m_hsize),
    .m_hburst(m_hburst), .m_hwdata(m_hwdata), .m_hready(m_hready), .m_hresp(m_hresp),
    .m_hrdata(m_hrdata), .s_hsel(s_hsel), .s_haddr(s_haddr), .s_htrans(s_htrans),
    .s_hwrite(s_hwrite), .s_hsize(s_hsize), .s_hburst(s_hburst), .s_hwdata(s_hwdata),
    .s_hready(s_hready), .s_hreadyout(s_hreadyout), .s_hresp(s_hresp), .s_hrdata(s_hrdata));
  mbm_slave_model slaves (.core_clk(core_clk), .rst(rst), .slow(slow), .s_hsel(s_hsel),
    .s_htrans(s_htrans), .s_hready(s_hready), .s_hreadyout(s_hreadyout), .s_hresp(s_hresp),
    .s_hrdata(s_hrdata));

  // Free-running 25 MHz clock.
  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end

  // Reports a mismatch and counts every comparison.
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // Prints the verdict and ends the run.
  task summarize;
    if (n_fail == 0 && n_tests > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // Resets for 16 cycles with the given boot pin, then waits past the pin capture.
  task do_reset(input logic pin);
    @(posedge core_clk);
    rst <= 1'b1;
    boot_source_select_pin <= pin;
    repeat (16) @(posedge core_clk);
    rst <= 1'b0;
    repeat (4) @(posedge core_clk);
  endtask

  // One single transfer of master m; returns data, response and cycles to completion.
  task automatic xfer(input int m, input logic [31:0] a, input bit wr,
                      output logic [31:0] d, output logic r, output int c);
    c = 0;
    @(posedge core_clk);
    m_haddr[m*32+:32] <= a;
    m_htrans[m*2+:2] <= mbm_pkg::HTRANS_NONSEQ;
    m_hwrite[m] <= wr;
    @(posedge core_clk);
    m_htrans[m*2+:2] <= mbm_pkg::HTRANS_IDLE;
    m_hwdata[m*32+:32] <= 32'h5A5A_A5A5 ^ a;
    do begin
      @(posedge core_clk);
      #1;
      c++;
    end while (m_hready[m] !== 1'b1 && c < 50);
    d = m_hrdata[m*32+:32];
    r = m_hresp[m];
  endtask

  // Every master against one address per slave and two unmapped ones: slave reached, or abort where closed or unmapped.
  task t_decode;
    logic [31:0] d;
    logic r;
    int c, e;
    for (int m = 0; m < 9; m++) begin
      for (int i = 0; i < 9; i++) begin
        e = EXP[i];
        if (i == 3 && m < 7) e = -1;
        if (i == 6 && !(m == 3 || m == 6 || m >= 7)) e = -1;
        slow <= m[0];
        xfer(m, ADR[i], i == 1, d, r, c);
        chk(c < 50, 1'b1);
        chk(r, e < 0);
        if (e >= 0 && i != 1) chk(d, 32'hC0DE_0000 | e);
      end
    end
    slow <= 1'b0;
  endtask

  // Boot pin picks the memory at zero for the processor; remap brings in SRAM.
  task t_boot;
    logic [31:0] d;
    logic r;
    int c;
    do_reset(1'b1);
    xfer(8, 32'h0000_0000, 1'b0, d, r, c);
    chk(d, 32'hC0DE_0000);
    xfer(0, 32'h0000_0000, 1'b0, d, r, c);
    chk(d, 32'hC0DE_0000);
    remap_cmd <= 1'b1;
    @(posedge core_clk);
    remap_cmd <= 1'b0;
    xfer(7, 32'h0000_0000, 1'b0, d, r, c);
    chk(d, 32'hC0DE_0001);
    do_reset(1'b0);
    xfer(8, 32'h0000_0000, 1'b0, d, r, c);
    chk(d, 32'hC0DE_0004);
  endtask

  // Contention on one slave under fixed priority and round robin; distinct slaves in parallel.
  task t_arb;
    logic [31:0] d2, d5;
    logic r2, r5;
    int c2, c5;
    arb_fixed <= 7'h7F;
    fork
      xfer(2, 32'h0040_0000, 1'b0, d2, r2, c2);
      xfer(5, 32'h0040_0000, 1'b0, d5, r5, c5);
    join
    chk(c5 < c2, 1'b1);
    // Round robin after owner 5 favours master 2; parking on 5 then favours 5.
    arb_fixed <= 7'h7E;
    xfer(5, 32'h0040_0000, 1'b0, d5, r5, c5);
    for (int k = 0; k < 2; k++) begin
      fork
        xfer(2, 32'h0040_0000, 1'b0, d2, r2, c2);
        xfer(5, 32'h0040_0000, 1'b0, d5, r5, c5);
      join
      chk(k ? c5 < c2 : c2 < c5, 1'b1);
      dflt_type <= 14'h0002;
      dflt_master <= 28'h000_0005;
    end
    fork
      xfer(0, 32'h0040_0000, 1'b0, d2, r2, c2);
      xfer(1, 32'h1000_0000, 1'b0, d5, r5, c5);
    join
    chk(c2 == c5, 1'b1);
    chk(d5, 32'hC0DE_0004);
  endtask

  // Cuts a hang short.
  initial begin
    #400000;
    n_fail++;
    summarize();
  end

  // Main sequence.
  initial begin
    rst = 1'b1;
    boot_source_select_pin = 1'b1;
    remap_cmd = 1'b0;
    slow = 1'b0;
    arb_fixed = 7'h7F;
    dflt_type = '0;
    dflt_master = '0;
    m_haddr = '0;
    m_htrans = '0;
    m_hwrite = '0;
    m_hsize = {9{3'h2}};
    m_hburst = '0;
    m_hwdata = '0;
    do_reset(1'b1);
    t_decode();
    t_arb();
    t_boot();
    summarize();
  end
endmodule // test_multilayer_bus_matrix
`default_nettype wire
